// *** core/fswd_core.sv ***
// Fail-safe watchdog timer with prewarning and reset request
`timescale 1ns/1ps
module fswd_core #(
    parameter int PREWARN_CYC = fswd_pkg::PREWARN_CYC   // Prewarning to reset request
) (
    input  wire logic        clock,                  // System clock, 50 MHz
    input  wire logic        nrst,                   // Asynchronous reset, active low
    input  wire logic        service_command,        // Service pulse
    input  wire logic        watchdog_off_command,   // Stop pulse
    input  wire logic        watchdog_on_command,    // Restart pulse
    input  wire logic        config_write,           // Load reload value and division
    input  wire logic [15:0] watchdog_reload_value,  // New reload value
    input  wire logic        slow_select_in,         // New division, high for slow
    output logic             prewarning_irq,         // One-cycle prewarning pulse
    output logic             reset_request,          // Held until reset
    output logic             watchdog_running,       // Counting
    output logic [15:0]      watchdog_count          // Present count
);

    // **************************************************************
    // State and storage
    // **************************************************************
    fswd_pkg::fswd_state_t state;         // Present state
    fswd_pkg::fswd_state_t next_state;    // Next state
    logic [15:0]           reload;        // Stored reload value
    logic                  slow;          // Stored division choice
    logic [15:0]           count;         // Watchdog counter
    logic [15:0]           next_count;    // Next counter value
    logic [15:0]           delay;         // Prewarning delay count
    logic [15:0]           next_delay;    // Next delay count

    // **************************************************************
    // Decoding
    // **************************************************************
    wire tick;            // Prescaler enable pulse
    wire in_run;          // Counting state
    wire in_off;          // Stopped state
    wire do_off;          // Stop taken
    wire do_on;           // Restart taken
    wire do_service;      // Service taken
    wire wrap;            // Counter wraps from all ones
    wire delay_done;      // Reset request due

    // Wrapping increment shared by the watchdog and delay counters
    function automatic logic [15:0] step_up(input logic [15:0] value);
        step_up = 16'(value + 16'h0001);
    endfunction : step_up

    assign in_run     = (state == fswd_pkg::FSWD_RUN);
    assign in_off     = (state == fswd_pkg::FSWD_OFF);
    // Once overflowed the sequence cannot be stopped: that is the fail-safe
    assign do_off     = watchdog_off_command && in_run;
    assign do_on      = watchdog_on_command && !watchdog_off_command && in_off;
    assign do_service = service_command && in_run && !do_off;
    assign wrap       = tick && in_run && !do_off && !do_service
                        && (count == fswd_pkg::COUNT_TOP);
    assign delay_done = (delay == 16'(PREWARN_CYC - 1));

    // Prescaler cleared by service and held at zero while not running
    fswd_prescaler #(
        .DIV_SLOW    (fswd_pkg::DIV_SLOW),
        .DIV_FAST    (fswd_pkg::DIV_FAST)
    ) fswd_prescaler_inst (
        .clock       (clock),
        .nrst        (nrst),
        .enable      (in_run && !do_off),
        .clear       (do_service),
        .slow_select (slow),
        .tick        (tick)
    );

    // **************************************************************
    // Next state
    // **************************************************************
    always_comb begin
        next_state = state;
        case (state)
            fswd_pkg::FSWD_RUN: begin
                if (do_off) begin
                    next_state = fswd_pkg::FSWD_OFF;
                end else if (wrap) begin
                    next_state = fswd_pkg::FSWD_PREWARN;
                end
            end
            fswd_pkg::FSWD_OFF: begin
                if (do_on) begin
                    next_state = fswd_pkg::FSWD_RUN;
                end
            end
            fswd_pkg::FSWD_PREWARN: begin
                if (delay_done) begin
                    next_state = fswd_pkg::FSWD_RESREQ;
                end
            end
            fswd_pkg::FSWD_RESREQ: begin
                next_state = fswd_pkg::FSWD_RESREQ;    // Only reset leaves here
            end
            default: begin
                next_state = fswd_pkg::FSWD_RESREQ;    // Unknown code is a failure
            end
        endcase
    end

    // Counter: load on service, step on tick, else hold
    assign next_count = do_service ? reload :
                        (tick && in_run && !do_off) ? step_up(count) :
                        count;
    // Delay counts only while prewarned
    assign next_delay = (state == fswd_pkg::FSWD_PREWARN) ? step_up(delay)
                                                          : 16'h0000;

    // **************************************************************
    // Registers
    // **************************************************************
    // State comes out of reset already running, no software needed
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= fswd_pkg::FSWD_RUN;
            count <= fswd_pkg::RELOAD_RESET;
            delay <= 16'h0000;
        end else begin
            state <= next_state;
            count <= next_count;
            delay <= next_delay;
        end
    end

    // Settings: documented defaults until software changes them
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reload <= fswd_pkg::RELOAD_RESET;
            slow   <= fswd_pkg::SLOW_RESET;
        end else if (config_write) begin
            reload <= watchdog_reload_value;
            slow   <= slow_select_in;
        end
    end

    // Outputs from flip-flops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prewarning_irq <= 1'b0;
            reset_request  <= 1'b0;
        end else begin
            prewarning_irq <= wrap;
            reset_request  <= reset_request
                              || (state == fswd_pkg::FSWD_PREWARN && delay_done);
        end
    end

    assign watchdog_running = in_run;
    assign watchdog_count   = count;

    // **************************************************************
    // Checks
    // **************************************************************
    localparam int PW_CYC = PREWARN_CYC;   // Local bound for delay ranges
    logic          settled;                // First clock after reset passed

    // Helper for the out-of-reset check
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            settled <= 1'b0;
        end else begin
            settled <= 1'b1;
        end
    end

    property p_run_from_reset;
        @(posedge clock) disable iff (!nrst)
        !settled |-> watchdog_running && count == fswd_pkg::RELOAD_RESET;
    endproperty
    a_run_from_reset: assert property (p_run_from_reset)
        else $error("Watchdog not running after reset");

    property p_off_stops;
        @(posedge clock) disable iff (!nrst)
        (watchdog_off_command && in_run) |=> in_off ##1 (in_off || watchdog_running)
                                             && $stable(count);
    endproperty
    a_off_stops: assert property (p_off_stops)
        else $error("Off command did not stop the watchdog");

    property p_on_starts;
        @(posedge clock) disable iff (!nrst)
        (watchdog_on_command && !watchdog_off_command && in_off) |=> watchdog_running;
    endproperty
    a_on_starts: assert property (p_on_starts)
        else $error("On command did not restart the watchdog");

    property p_service_load;
        @(posedge clock) disable iff (!nrst)
        (service_command && in_run && !watchdog_off_command && !config_write)
        |=> count == $past(reload) && !prewarning_irq;
    endproperty
    a_service_load: assert property (p_service_load)
        else $error("Service did not load the reload value");

    property p_step;
        @(posedge clock) disable iff (!nrst)
        (tick && in_run && !service_command && !watchdog_off_command)
        |=> count == 16'($past(count) + 16'h0001);
    endproperty
    a_step: assert property (p_step)
        else $error("Counter did not advance on tick");

    sequence s_overflow;
        tick && in_run && !service_command && !watchdog_off_command
        && count == fswd_pkg::COUNT_TOP;
    endsequence
    sequence s_prewarn;
        prewarning_irq && !reset_request;
    endsequence

    property p_overflow_prewarn;
        @(posedge clock) disable iff (!nrst)
        s_overflow |=> s_prewarn ##1 !prewarning_irq;
    endproperty
    a_overflow_prewarn: assert property (p_overflow_prewarn)
        else $error("Overflow gave no prewarning");

    property p_reset_after;
        @(posedge clock) disable iff (!nrst)
        s_prewarn |-> !reset_request [*1] ##[PW_CYC:PW_CYC] reset_request;
    endproperty
    a_reset_after: assert property (p_reset_after)
        else $error("Reset request not at fixed delay after prewarning");

    property p_reset_holds;
        @(posedge clock) disable iff (!nrst)
        reset_request |=> reset_request && !watchdog_running;
    endproperty
    a_reset_holds: assert property (p_reset_holds)
        else $error("Reset request dropped");

    property p_defaults;
        @(posedge clock) disable iff (!nrst)
        !settled |-> reload == fswd_pkg::RELOAD_RESET && slow == fswd_pkg::SLOW_RESET;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("Default interval settings wrong");

endmodule : fswd_core

// *** core/fswd_pkg.sv ***
// Package with the constants and types of the fail-safe watchdog timer
// Summary of operation
// - Watchdog runs after every application reset
// - Off/on commands stop and restart, until overflow
// - Overflow gives prewarning, then reset request
// - 16-bit counter, prescaler 16384 or 256
// - Service loads reload value, clears prescaler
// - Default interval about 6.5 ms at 10 MHz
package fswd_pkg;

    // **************************************************************
    // Widths and prescaler divisions
    // **************************************************************
    localparam int          COUNT_W      = 16;         // Counter width
    localparam int          PRESC_W      = 14;         // Prescaler width
    localparam int          DIV_SLOW     = 16384;      // Slow division
    localparam int          DIV_FAST     = 256;        // Fast division

    // **************************************************************
    // Reset values
    // **************************************************************
    // 256 ticks of 256 clocks: 6.55 ms at 10 MHz
    localparam logic [15:0] RELOAD_RESET = 16'hff00;   // Default reload
    localparam logic        SLOW_RESET   = 1'b0;       // Default fast division
    localparam logic [15:0] COUNT_TOP    = 16'hffff;   // Last count before wrap

    // **************************************************************
    // Timing
    // **************************************************************
    localparam int          CLOCK_HZ     = 50000000;   // System clock rate
    localparam int          PREWARN_NS   = 5000;       // Prewarning to reset request
    // Longest time: round down, at least one cycle
    localparam int          PREWARN_CYC  = (PREWARN_NS / (1000000000 / CLOCK_HZ)) < 1 ? 1 :
                                           (PREWARN_NS / (1000000000 / CLOCK_HZ));

    // **************************************************************
    // States, Gray along run, prewarn, reset request
    // **************************************************************
    typedef enum logic [1:0] {
        FSWD_RUN     = 2'b00,   // Counting
        FSWD_PREWARN = 2'b01,   // Overflowed, waiting to reset
        FSWD_RESREQ  = 2'b11,   // Reset request held
        FSWD_OFF     = 2'b10    // Stopped by software
    } fswd_state_t;

endpackage : fswd_pkg

// *** core/fswd_prescaler.sv ***
// Prescaler that divides the system clock by 16384 or 256
`timescale 1ns/1ps
module fswd_prescaler #(
    parameter int DIV_SLOW = fswd_pkg::DIV_SLOW,   // Slow division
    parameter int DIV_FAST = fswd_pkg::DIV_FAST    // Fast division
) (
    input  wire logic clock,        // System clock
    input  wire logic nrst,         // Asynchronous reset, active low
    input  wire logic enable,       // Counting allowed
    input  wire logic clear,        // Restart division
    input  wire logic slow_select,  // Select slow division
    output logic      tick          // One-cycle enable pulse
);

    // **************************************************************
    // Division counter
    // **************************************************************
    localparam int                PRESC_W = fswd_pkg::PRESC_W;  // Local width for size casts
    logic [fswd_pkg::PRESC_W-1:0] count;       // Clocks in this tick
    logic [fswd_pkg::PRESC_W-1:0] next_count;  // Next count
    wire  [fswd_pkg::PRESC_W-1:0] limit;       // Last count of a tick
    wire                          at_limit;    // Division complete

    // Limit follows the selection at once
    assign limit      = slow_select ? PRESC_W'(DIV_SLOW - 1)
                                    : PRESC_W'(DIV_FAST - 1);
    assign at_limit   = (count >= limit);   // Also catches a late switch to fast
    assign tick       = enable && !clear && at_limit;
    // Clear and disable both restart the division from zero
    assign next_count = (clear || !enable || at_limit) ? '0
                                                       : count + 1'b1;

    // Division register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // **************************************************************
    // Checks
    // **************************************************************
    property p_prescale_span;
        @(posedge clock) disable iff (!nrst)
        (enable && !clear && count == '0 && !slow_select) ##1
        (enable && !clear && !slow_select) [*8]
        |-> !tick;
    endproperty
    a_prescale_span: assert property (p_prescale_span)
        else $error("Prescaler ticked too early");

endmodule : fswd_prescaler

// *** tb/fswd_core_test.sv ***
// Self-checking testbench for the fail-safe watchdog timer core
`timescale 1ns/1ps
module fswd_core_test;
    // ****************************************************************
    // Bench signals and counters
    // ****************************************************************
    localparam int PREWARN = 4;          // Short prewarning delay keeps the run brief
    localparam int LIMIT   = 60000;      // Cycle ceiling, about three times the need
    logic          clock;                // System clock, 20 ns
    logic          nrst;                 // Reset, active low
    logic          service_command;      // Service pulse
    logic          watchdog_off_command; // Stop pulse
    logic          watchdog_on_command;  // Restart pulse
    logic          config_write;         // Reload and division strobe
    logic [15:0]   watchdog_reload_value;// Reload value driven
    logic          slow_select_in;       // Division select driven
    logic          prewarning_irq;       // Prewarning pulse seen
    logic          reset_request;        // Reset request seen
    logic          watchdog_running;     // Running flag seen
    logic [15:0]   watchdog_count;       // Count seen
    int            n_fail;               // Mismatches
    int            compares;             // Comparisons made
    int            cycles;               // Clock cycles elapsed

    fswd_core #(.PREWARN_CYC(PREWARN)) fswd_core_inst (
        .clock                 (clock),
        .nrst                  (nrst),
        .service_command       (service_command),
        .watchdog_off_command  (watchdog_off_command),
        .watchdog_on_command   (watchdog_on_command),
        .config_write          (config_write),
        .watchdog_reload_value (watchdog_reload_value),
        .slow_select_in        (slow_select_in),
        .prewarning_irq        (prewarning_irq),
        .reset_request         (reset_request),
        .watchdog_running      (watchdog_running),
        .watchdog_count        (watchdog_count)
    );

    // ****************************************************************
    // Clock and hang guard
    // ****************************************************************
    // Free-running clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Cuts a hang short and counts it as a mismatch
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles >= LIMIT) begin
            n_fail = n_fail + 1;
            conclude();
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Waits n edges, then 1 ns so inputs change off the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    // Compares a seen value with the expected one
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Holds reset for two cycles; all strobes idle
    task automatic do_reset();
        nrst = 1'b0;
        cyc(2);
        nrst = 1'b1;
    endtask : do_reset

    // Writes reload value and division, one-cycle strobe
    task automatic cfg(input logic [15:0] val, input logic slow);
        config_write          = 1'b1;
        watchdog_reload_value = val;
        slow_select_in        = slow;
        cyc(1);
        config_write = 1'b0;
    endtask : cfg

    // One-cycle service pulse; the count shows the reload after it
    task automatic serve();
        service_command = 1'b1;
        cyc(1);
        service_command = 1'b0;
    endtask : serve

    // Waits for the prewarning under a bound, then times the reset request
    task automatic overflow_seq(input int bound);
        int k;
        k = 0;
        while (prewarning_irq !== 1'b1 && k < bound) begin
            check("early_reset_request", reset_request, 1'b0);
            cyc(1);
            k = k + 1;
        end
        check("prewarning", prewarning_irq, 1'b1);
        check("running_after_overflow", watchdog_running, 1'b0);
        check("count_wrapped", watchdog_count, 16'h0000);
        serve();                                                 // Ignored after overflow
        check("prewarning_one_cycle", prewarning_irq, 1'b0);
        check("service_refused", watchdog_count, 16'h0000);
        cyc(PREWARN - 2);
        check("reset_request_late", reset_request, 1'b0);
        cyc(1);
        check("reset_request", reset_request, 1'b1);
    endtask : overflow_seq

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Counting starts by itself, default reload and fast division
    task automatic t_reset();
        check("running_at_reset", watchdog_running, 1'b1);
        check("count_at_reset", watchdog_count, 16'hff00);
        cyc(300);
        check("first_step", watchdog_count, 16'hff01);
        $display("test reset done");
    endtask : t_reset

    // Service reloads and clears the prescaler mid-division
    task automatic t_service();
        cfg(16'hfffe, 1'b0);
        serve();
        check("reload", watchdog_count, 16'hfffe);
        cyc(199);
        serve();
        cyc(199);
        check("prescaler_cleared", watchdog_count, 16'hfffe);
        cyc(70);
        check("step_after_service", watchdog_count, 16'hffff);
        serve();
        $display("test service done");
    endtask : t_service

    // Stop and restart, with off winning over a same-cycle on
    task automatic t_offon();
        watchdog_off_command = 1'b1;
        watchdog_on_command  = 1'b1;
        cyc(1);
        watchdog_on_command  = 1'b0;
        check("stopped", watchdog_running, 1'b0);
        cyc(1);
        watchdog_off_command = 1'b0;
        serve();                                                 // Ignored while stopped
        cyc(600);
        check("count_held", watchdog_count, 16'hfffe);
        watchdog_off_command = 1'b1;
        watchdog_on_command  = 1'b1;
        cyc(1);
        watchdog_off_command = 1'b0;
        check("off_wins_while_stopped", watchdog_running, 1'b0);
        cyc(1);
        watchdog_on_command = 1'b0;
        check("restarted", watchdog_running, 1'b1);
        $display("test off/on done");
    endtask : t_offon

    // Unserviced wrap in fast division
    task automatic t_overflow_fast();
        overflow_seq(600);
        $display("test fast overflow done");
    endtask : t_overflow_fast

    // Slow division: one tick from all-ones overflows after 16384 clocks
    task automatic t_slow();
        check("no_request_after_reset", reset_request, 1'b0);
        cfg(16'hffff, 1'b1);
        serve();
        cyc(16000);
        check("slow_no_tick", watchdog_count, 16'hffff);
        check("slow_running", watchdog_running, 1'b1);
        overflow_seq(600);
        $display("test slow overflow done");
    endtask : t_slow

    // ****************************************************************
    // Closing report and main sequence
    // ****************************************************************
    // Prints the counts and the verdict, then ends the run
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    // Every input is given a value at time zero
    initial begin
        n_fail                = 0;
        compares              = 0;
        cycles                = 0;
        nrst                  = 1'b0;
        service_command       = 1'b0;
        watchdog_off_command  = 1'b0;
        watchdog_on_command   = 1'b0;
        config_write          = 1'b0;
        watchdog_reload_value = 16'h0000;
        slow_select_in        = 1'b0;
        do_reset();
        t_reset();
        t_service();
        t_offon();
        t_overflow_fast();
        do_reset();
        t_slow();
        conclude();
    end
endmodule : fswd_core_test
